/* inc/gpb_consts.svh */
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH
`define GPB_ADDR_DATA_A 8'hC0
`define GPB_ADDR_DATA_B 8'hC1
`define GPB_ADDR_DIR_A 8'hC4
`define GPB_ADDR_DIR_B 8'hC5
`define GPB_ADDR_OPT_A 8'hCC
`define GPB_ADDR_OPT_B 8'hCD
`define GPB_REG_RESET 8'h00
`define GPB_BONDED_A 8'h0E
`define GPB_BONDED_B 8'hEB
`define GPB_ANALOG_B 8'hE8
`define GPB_HISINK_A 8'h0E
`define GPB_TRIG_FALL 2'h0
`define GPB_TRIG_RISE 2'h1
`define GPB_TRIG_LOW 2'h2
`endif

/* inc/gpb_pkg.sv */
package gpb_pkg;
  typedef enum logic [1:0] {
    GPB_IN_PULLUP,
    GPB_IN_FLOAT,
    GPB_IN_PULLUP_IRQ,
    GPB_IN_ANALOG
  } gpb_in_mode_t;
  typedef enum logic [1:0] {
    GPB_RUN,
    GPB_WAIT,
    GPB_STOP
  } gpb_power_t;
endpackage

/* inc/gpb_cfg_if.sv */
interface gpb_cfg_if;
  logic [7:0] dir;
  logic [7:0] opt;
  logic [7:0] dat;
  logic [7:0] pin;
  logic [7:0] rd;
  logic [7:0] oe_n;
  logic [7:0] drv;
  logic [7:0] pull;
  logic [7:0] irq_en;
  logic [7:0] ana;
  modport ctl (output dir, opt, dat, pin,
    input rd, oe_n, drv, pull, irq_en, ana);
  modport bank (input dir, opt, dat, pin,
    output rd, oe_n, drv, pull, irq_en, ana);
endinterface

/* src/gpb_bank.sv */
module gpb_bank #(
  parameter logic [7:0] BONDED = 8'hFF,
  parameter logic [7:0] ANALOG = 8'h00
) (
  gpb_cfg_if.bank cfg
);
  import gpb_pkg::*;
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      gpb_in_mode_t m;
      logic live;
      assign m = gpb_in_mode_t'({cfg.opt[i], cfg.dat[i]});
      assign live = BONDED[i];
      // Output: 0 drives low, 1 high (push-pull) or floats (open-drain)
      assign cfg.oe_n[i] = ~(live & cfg.dir[i] &
        (~cfg.dat[i] | cfg.opt[i])); // RL10 RL11 RL17 RL6
      assign cfg.drv[i] = cfg.dat[i];
      // Input modes from option and data bits
      assign cfg.pull[i] = live & ~cfg.dir[i] & ~cfg.dat[i]; // RL15 RL4 RL5
      assign cfg.irq_en[i] = live & ~cfg.dir[i] &
        (m == GPB_IN_PULLUP_IRQ); // RL4 RL9 RL12
      assign cfg.ana[i] = live & ANALOG[i] & ~cfg.dir[i] &
        (m == GPB_IN_ANALOG); // RL7 RL15
      // Readback: latch for outputs, pin for inputs
      assign cfg.rd[i] = cfg.dir[i] ? cfg.dat[i] : cfg.pin[i]; // RL8
    end
  endgenerate
endmodule

/* src/gpb_port_pair.sv */
// Notes on behaviour
// (RL1) Wait mode leaves pins unchanged; enabled pin interrupt ends wait.
// (RL2) Stop mode leaves pins unchanged; enabled pin interrupt ends stop.
// (RL3) Interrupt only for interrupt-input pins with global enable set.
// (RL4) Direction 0, option 1, data 0: pull-up input with interrupt.
// (RL5) After reset all pins are pull-up inputs without interrupt.
// (RL6) Bank B pins 5 mA class; bank A pins 1-3 high sink.
// (RL7) Bonded: A1-A3, B0 B1 B3 B5-B7; analog only B3, B5-B7.
// (RL8) Data read gives latch for outputs, pin level for inputs.
// (RL9) Data write on input pin changes its input configuration.
// (RL10) Direction bit 0 input, 1 output; bit x controls pin x.
// (RL11) Output option 0 open-drain, option 1 push-pull.
// (RL12) Option change on input pin changes input configuration.
// (RL13) All six registers reset to 00h and are fully writable.
// (RL14) Data C0h/C1h, direction C4h/C5h, option CCh/CDh.
// (RL15) Input modes: pull-up, floating, pull-up with interrupt, analog.
// (RL16) Trigger per bank: falling edge, rising edge or low level.
// (RL17) Output data latched; 0 low, 1 high or floating.
// (RL18) One request per bank from enabled pins, gated by global enable.
`include "gpb_consts.svh"
module gpb_port_pair (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic global_interrupt_enable_in,
  input wire logic [1:0] trig_a_in,
  input wire logic [1:0] trig_b_in,
  input wire gpb_pkg::gpb_power_t power_in,
  output logic wake_out,
  output logic irq_a_out,
  output logic irq_b_out,
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_b_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe_n_out,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_oe_n_out,
  output logic [7:0] pull_a_out,
  output logic [7:0] pull_b_out,
  output logic [7:0] analog_sel_out
);
  import gpb_pkg::*;
  logic [7:0] dat_a_q, dat_b_q, dir_a_q, dir_b_q, opt_a_q, opt_b_q;
  logic [7:0] pa_s1_q, pa_q, pb_s1_q, pb_q, pa_prev_q, pb_prev_q;
  logic gen_s1_q, gen_q;
  logic [1:0] ta_s1_q, ta_q, tb_s1_q, tb_q;
  logic irq_a_d, irq_b_d;
  gpb_cfg_if ca();
  gpb_cfg_if cb();

  function automatic logic hit(input logic [7:0] en, input logic [7:0] cur,
    input logic [7:0] prev, input logic [1:0] trig);
    logic [7:0] ev;
    ev = 8'h00;
    if (trig == `GPB_TRIG_FALL)
      ev = prev & ~cur;
    else if (trig == `GPB_TRIG_RISE)
      ev = ~prev & cur;
    else if (trig == `GPB_TRIG_LOW)
      ev = ~cur;
    return |(ev & en); // RL16
  endfunction

  // Pin, global enable and trigger inputs synchronised
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pa_s1_q <= 8'hFF;
      pa_q <= 8'hFF;
      pb_s1_q <= 8'hFF;
      pb_q <= 8'hFF;
      pa_prev_q <= 8'hFF;
      pb_prev_q <= 8'hFF;
      gen_s1_q <= 1'b0;
      gen_q <= 1'b0;
      ta_s1_q <= 2'h0;
      ta_q <= 2'h0;
      tb_s1_q <= 2'h0;
      tb_q <= 2'h0;
    end
    else
    begin
      pa_s1_q <= pin_a_in;
      pa_q <= pa_s1_q;
      pb_s1_q <= pin_b_in;
      pb_q <= pb_s1_q;
      pa_prev_q <= pa_q;
      pb_prev_q <= pb_q;
      gen_s1_q <= global_interrupt_enable_in;
      gen_q <= gen_s1_q;
      ta_s1_q <= trig_a_in;
      ta_q <= ta_s1_q;
      tb_s1_q <= trig_b_in;
      tb_q <= tb_s1_q;
    end
  end

  // Register writes; power mode never touches them
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      dat_a_q <= `GPB_REG_RESET; // RL5 RL13
      dat_b_q <= `GPB_REG_RESET;
      dir_a_q <= `GPB_REG_RESET;
      dir_b_q <= `GPB_REG_RESET;
      opt_a_q <= `GPB_REG_RESET;
      opt_b_q <= `GPB_REG_RESET;
    end
    else if (wr_in)
    begin
      if (addr_in == `GPB_ADDR_DATA_A) // RL14 RL9 RL17
        dat_a_q <= wdata_in;
      else if (addr_in == `GPB_ADDR_DATA_B)
        dat_b_q <= wdata_in;
      else if (addr_in == `GPB_ADDR_DIR_A) // RL10
        dir_a_q <= wdata_in;
      else if (addr_in == `GPB_ADDR_DIR_B)
        dir_b_q <= wdata_in;
      else if (addr_in == `GPB_ADDR_OPT_A) // RL11 RL12
        opt_a_q <= wdata_in;
      else if (addr_in == `GPB_ADDR_OPT_B)
        opt_b_q <= wdata_in;
    end
  end

  assign ca.dir = dir_a_q;
  assign ca.opt = opt_a_q;
  assign ca.dat = dat_a_q;
  assign ca.pin = pa_q;
  assign cb.dir = dir_b_q;
  assign cb.opt = opt_b_q;
  assign cb.dat = dat_b_q;
  assign cb.pin = pb_q;

  gpb_bank #(.BONDED(`GPB_BONDED_A), .ANALOG(8'h00)) u_bank_a (
    .cfg(ca.bank)
  );
  gpb_bank #(.BONDED(`GPB_BONDED_B), .ANALOG(`GPB_ANALOG_B)) u_bank_b (
    .cfg(cb.bank)
  );

  // Read data registered; unmapped addresses read 00h
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      if (addr_in == `GPB_ADDR_DATA_A) // RL8
        rdata_out <= ca.rd;
      else if (addr_in == `GPB_ADDR_DATA_B)
        rdata_out <= cb.rd;
      else if (addr_in == `GPB_ADDR_DIR_A)
        rdata_out <= dir_a_q;
      else if (addr_in == `GPB_ADDR_DIR_B)
        rdata_out <= dir_b_q;
      else if (addr_in == `GPB_ADDR_OPT_A)
        rdata_out <= opt_a_q;
      else if (addr_in == `GPB_ADDR_OPT_B)
        rdata_out <= opt_b_q;
      else
        rdata_out <= 8'h00;
    end
  end

  // Pin drive; high-sink class on bank A pins 1-3 is a pad property
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pin_a_out <= 8'h00;
      pin_b_out <= 8'h00;
      pin_a_oe_n_out <= 8'hFF;
      pin_b_oe_n_out <= 8'hFF;
      pull_a_out <= 8'h00;
      pull_b_out <= 8'h00;
      analog_sel_out <= 8'h00;
    end
    else
    begin
      pin_a_out <= ca.drv; // RL6 RL1 RL2
      pin_b_out <= cb.drv;
      pin_a_oe_n_out <= ca.oe_n;
      pin_b_oe_n_out <= cb.oe_n;
      pull_a_out <= ca.pull;
      pull_b_out <= cb.pull;
      analog_sel_out <= cb.ana;
    end
  end

  // Interrupt requests per bank
  assign irq_a_d = gen_q & hit(ca.irq_en, pa_q, pa_prev_q, ta_q); // RL3 RL18
  assign irq_b_d = gen_q & hit(cb.irq_en, pb_q, pb_prev_q, tb_q); // RL3 RL18

  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      irq_a_out <= 1'b0;
      irq_b_out <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      irq_a_out <= irq_a_d;
      irq_b_out <= irq_b_d;
      wake_out <= (power_in != GPB_RUN) & (irq_a_d | irq_b_d); // RL1 RL2
    end
  end

  reset_regs_a: assert property (@(posedge mclk_in) // RL13
    $rose(rstn_in) |-> (dat_a_q | dat_b_q | dir_a_q | dir_b_q | opt_a_q |
      opt_b_q) == `GPB_REG_RESET)
    else $error("registers not cleared by reset");
  reset_pins_a: assert property (@(posedge mclk_in) // RL5
    $rose(rstn_in) |-> pin_a_oe_n_out == 8'hFF &&
      pin_b_oe_n_out == 8'hFF && !irq_a_out && !irq_b_out)
    else $error("pins not released by reset");
  reset_pull_a: assert property (@(posedge mclk_in) // RL5
    disable iff (!rstn_in)
    $rose(rstn_in) |=> pull_a_out == `GPB_BONDED_A &&
      pull_b_out == `GPB_BONDED_B && analog_sel_out == 8'h00)
    else $error("reset state not pull-up input");
  dir_write_a: assert property (@(posedge mclk_in) // RL14
    disable iff (!rstn_in)
    wr_in && addr_in == `GPB_ADDR_DIR_A |=> dir_a_q == $past(wdata_in))
    else $error("direction A write lost");
  dir_b_write_a: assert property (@(posedge mclk_in) // RL10
    disable iff (!rstn_in)
    wr_in && addr_in == `GPB_ADDR_DIR_B |=> dir_b_q == $past(wdata_in))
    else $error("direction B write lost");
  dat_a_write_a: assert property (@(posedge mclk_in) // RL17
    disable iff (!rstn_in)
    wr_in && addr_in == `GPB_ADDR_DATA_A |=> dat_a_q == $past(wdata_in))
    else $error("data A write lost");
  opt_a_write_a: assert property (@(posedge mclk_in) // RL11
    disable iff (!rstn_in)
    wr_in && addr_in == `GPB_ADDR_OPT_A |=> opt_a_q == $past(wdata_in))
    else $error("option A write lost");
  read_back_a: assert property (@(posedge mclk_in) // RL8
    disable iff (!rstn_in)
    rd_in && addr_in == `GPB_ADDR_DATA_B |=>
      rdata_out == (($past(dir_b_q) & $past(dat_b_q)) |
      (~$past(dir_b_q) & $past(pb_q))))
    else $error("data read mixes latch and pin wrongly");
  read_latch_a: assert property (@(posedge mclk_in) // RL8
    disable iff (!rstn_in)
    rd_in && addr_in == `GPB_ADDR_DATA_A |=>
      rdata_out == (($past(dir_a_q) & $past(dat_a_q)) |
      (~$past(dir_a_q) & $past(pa_q))))
    else $error("bank A data read wrong");
  read_cfg_a: assert property (@(posedge mclk_in) // RL14
    disable iff (!rstn_in)
    rd_in && addr_in == `GPB_ADDR_OPT_B |=> rdata_out == $past(opt_b_q))
    else $error("option B read wrong");
  read_unmapped_a: assert property (@(posedge mclk_in) // RL14
    disable iff (!rstn_in)
    rd_in && addr_in != `GPB_ADDR_DATA_A && addr_in != `GPB_ADDR_DATA_B &&
      addr_in != `GPB_ADDR_DIR_A && addr_in != `GPB_ADDR_DIR_B &&
      addr_in != `GPB_ADDR_OPT_A && addr_in != `GPB_ADDR_OPT_B |=>
      rdata_out == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (@(posedge mclk_in) // RL8
    disable iff (!rstn_in)
    !rd_in |=> $stable(rdata_out))
    else $error("read data changed without a read");
  gen_gate_a: assert property (@(posedge mclk_in) // RL3
    disable iff (!rstn_in)
    !gen_q |=> !irq_a_out && !irq_b_out)
    else $error("request without global enable");
  irq_mode_a: assert property (@(posedge mclk_in) // RL18
    disable iff (!rstn_in)
    ca.irq_en == 8'h00 && cb.irq_en == 8'h00 |=> !irq_a_out && !irq_b_out)
    else $error("request from non-interrupt pin");
  fall_event_a: assert property (@(posedge mclk_in) // RL16
    disable iff (!rstn_in)
    gen_q && tb_q == `GPB_TRIG_FALL && cb.irq_en[1] && pb_prev_q[1] &&
      !pb_q[1] |=> irq_b_out)
    else $error("falling edge request missed");
  rise_event_a: assert property (@(posedge mclk_in) // RL16
    disable iff (!rstn_in)
    gen_q && tb_q == `GPB_TRIG_RISE && cb.irq_en[1] && !pb_prev_q[1] &&
      pb_q[1] |=> irq_b_out)
    else $error("rising edge request missed");
  low_level_a: assert property (@(posedge mclk_in) // RL16
    disable iff (!rstn_in)
    gen_q && ta_q == `GPB_TRIG_LOW && ca.irq_en[1] && !pa_q[1] |=>
      irq_a_out)
    else $error("low level request missed");
  no_trig_a: assert property (@(posedge mclk_in) // RL16
    disable iff (!rstn_in)
    ta_q == 2'h3 && tb_q == 2'h3 |=> !irq_a_out && !irq_b_out)
    else $error("request with trigger off");
  pushpull_drive_a: assert property (@(posedge mclk_in) // RL11
    disable iff (!rstn_in)
    dir_a_q[1] && opt_a_q[1] && dat_a_q[1] |=>
      !pin_a_oe_n_out[1] && pin_a_out[1])
    else $error("push-pull high not driven");
  pushpull_low_a: assert property (@(posedge mclk_in) // RL17
    disable iff (!rstn_in)
    dir_a_q[1] && opt_a_q[1] && !dat_a_q[1] |=>
      !pin_a_oe_n_out[1] && !pin_a_out[1])
    else $error("push-pull low not driven");
  opendrain_float_a: assert property (@(posedge mclk_in) // RL17
    disable iff (!rstn_in)
    dir_a_q[2] && !opt_a_q[2] && dat_a_q[2] |=> pin_a_oe_n_out[2])
    else $error("open-drain high driven");
  opendrain_low_a: assert property (@(posedge mclk_in) // RL11
    disable iff (!rstn_in)
    dir_a_q[2] && !opt_a_q[2] && !dat_a_q[2] |=>
      !pin_a_oe_n_out[2] && !pin_a_out[2])
    else $error("open-drain low not driven");
  input_pull_a: assert property (@(posedge mclk_in) // RL4
    disable iff (!rstn_in)
    !dir_b_q[1] && !dat_b_q[1] |=> pull_b_out[1] && pin_b_oe_n_out[1])
    else $error("pull-up input misconfigured");
  input_float_a: assert property (@(posedge mclk_in) // RL15
    disable iff (!rstn_in)
    !dir_b_q[0] && !opt_b_q[0] && dat_b_q[0] |=>
      !pull_b_out[0] && pin_b_oe_n_out[0])
    else $error("floating input misconfigured");
  analog_sel_a: assert property (@(posedge mclk_in) // RL15
    disable iff (!rstn_in)
    !dir_b_q[3] && opt_b_q[3] && dat_b_q[3] |=>
      analog_sel_out[3] && !pull_b_out[3])
    else $error("analog input not selected");
  output_no_pull_a: assert property (@(posedge mclk_in) // RL10
    disable iff (!rstn_in)
    dir_b_q[7] |=> !pull_b_out[7] && !analog_sel_out[7])
    else $error("output pin keeps input options");
  analog_only_a: assert property (@(posedge mclk_in) // RL7
    disable iff (!rstn_in)
    1'b1 |=> (analog_sel_out & ~`GPB_ANALOG_B) == 8'h00)
    else $error("analog on non-analog pin");
  unbonded_idle_a: assert property (@(posedge mclk_in) // RL7
    disable iff (!rstn_in)
    1'b1 |=> ((~pin_a_oe_n_out | pull_a_out) & ~`GPB_BONDED_A) == 8'h00 &&
      ((~pin_b_oe_n_out | pull_b_out) & ~`GPB_BONDED_B) == 8'h00)
    else $error("unbonded pin driven or pulled");
  wake_irq_a: assert property (@(posedge mclk_in) // RL2
    disable iff (!rstn_in)
    power_in == GPB_STOP && (irq_a_d || irq_b_d) |=> wake_out)
    else $error("stop not ended by pin interrupt");
  wait_wake_a: assert property (@(posedge mclk_in) // RL1
    disable iff (!rstn_in)
    power_in == GPB_WAIT && (irq_a_d || irq_b_d) |=> wake_out)
    else $error("wait not ended by pin interrupt");
  power_keep_a: assert property (@(posedge mclk_in) // RL1 RL2
    disable iff (!rstn_in)
    power_in != GPB_RUN && !$past(wr_in) |=>
      $stable(pin_a_oe_n_out) && $stable(pin_b_oe_n_out) &&
      $stable(pin_a_out) && $stable(pin_b_out))
    else $error("pin drive changed in low-power state");
endmodule

/* verification/gpb_pins.sv */
module gpb_pins (
  input wire logic clk_in,
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] pull_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic t_q = 1'b0;
  // An undriven, unpulled pin toggles so a stale level is never trusted
  always @(posedge clk_in)
  begin
    t_q <= ~t_q;
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!oe_n_in[i])
        pin_out[i] = drv_in[i];
      else if (ext_en_in[i])
        pin_out[i] = ext_in[i];
      else if (pull_in[i])
        pin_out[i] = 1'b1;
      else
        pin_out[i] = t_q ^ i[0];
    end
  end
endmodule

/* verification/bidir_io_port_pair_bench.sv */
`include "gpb_consts.svh"
module bidir_io_port_pair_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpb_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, gen = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
  logic [1:0] trig_a = 2'h3, trig_b = 2'h3;
  gpb_power_t pwr = GPB_RUN;
  logic wake, irq_a, irq_b;
  logic [7:0] pa_i, pb_i, pa_o, pa_oe_n, pb_o, pb_oe_n, pu_a, pu_b, ana;
  logic [7:0] ea_en = 8'h00, ea = 8'h00, eb_en = 8'h00, eb = 8'h00;
  int n_mismatch = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  gpb_port_pair uut (.mclk_in(clk), .rstn_in(rstn), .addr_in(addr),
    .wdata_in(wdat), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
    .global_interrupt_enable_in(gen), .trig_a_in(trig_a),
    .trig_b_in(trig_b), .power_in(pwr), .wake_out(wake),
    .irq_a_out(irq_a), .irq_b_out(irq_b), .pin_a_in(pa_i),
    .pin_b_in(pb_i), .pin_a_out(pa_o), .pin_a_oe_n_out(pa_oe_n),
    .pin_b_out(pb_o), .pin_b_oe_n_out(pb_oe_n), .pull_a_out(pu_a),
    .pull_b_out(pu_b), .analog_sel_out(ana));
  gpb_pins pins_a (.clk_in(clk), .drv_in(pa_o), .oe_n_in(pa_oe_n),
    .pull_in(pu_a), .ext_en_in(ea_en), .ext_in(ea), .pin_out(pa_i));
  gpb_pins pins_b (.clk_in(clk), .drv_in(pb_o), .oe_n_in(pb_oe_n),
    .pull_in(pu_b), .ext_en_in(eb_en), .ext_in(eb), .pin_out(pb_i));
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdat = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdat;
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_bit(ref logic b, input logic exp, string nm);
    int k;
    for (k = 0; k < 12 && b !== exp; k++)
      @(negedge clk);
    chk(nm, {7'h00, b}, {7'h00, exp});
  endtask
  task automatic t_regs();
    logic [7:0] v;
    logic [7:0] adr[6] = '{`GPB_ADDR_DIR_A, `GPB_ADDR_DIR_B,
      `GPB_ADDR_OPT_A, `GPB_ADDR_OPT_B, `GPB_ADDR_DATA_A, `GPB_ADDR_DATA_B};
    chk("oe_n_a", pa_oe_n, 8'hFF);
    chk("pull_a", pu_a, `GPB_BONDED_A);
    chk("pull_b", pu_b, `GPB_BONDED_B);
    for (int i = 0; i < 6; i++)
    begin
      // Data registers read back their latch only on output pins
      if (i == 4)
      begin
        wr_reg(`GPB_ADDR_DIR_A, 8'hFF);
        wr_reg(`GPB_ADDR_DIR_B, 8'hFF);
      end
      rd_reg(adr[i], v);
      chk("reset", v, `GPB_REG_RESET);
      wr_reg(adr[i], 8'hA5);
      rd_reg(adr[i], v);
      chk("rw", v, 8'hA5);
      wr_reg(adr[i], 8'h00);
    end
    wr_reg(`GPB_ADDR_DIR_A, 8'h00);
    wr_reg(`GPB_ADDR_DIR_B, 8'h00);
    rd_reg(8'hC2, v);
    chk("unmapped", v, 8'h00);
  endtask
  task automatic t_out();
    logic [7:0] v;
    wr_reg(`GPB_ADDR_DIR_A, 8'h06);
    wr_reg(`GPB_ADDR_OPT_A, 8'h02);
    wr_reg(`GPB_ADDR_DATA_A, 8'h06);
    settle();
    chk("oe_n_od", pa_oe_n, 8'hFD);
    chk("drv_pp", pa_o & 8'h02, 8'h02);
    chk("pull_in3", pu_a & 8'h08, 8'h08);
    rd_reg(`GPB_ADDR_DATA_A, v);
    chk("rd_mix", v & 8'h0E, 8'h0E);
    wr_reg(`GPB_ADDR_DATA_A, 8'h00);
    settle();
    chk("oe_n_low", pa_oe_n, 8'hF9);
    chk("drv_low", pa_o & 8'h06, 8'h00);
    rd_reg(`GPB_ADDR_DATA_A, v);
    chk("rd_latch", v & 8'h0E, 8'h08);
    wr_reg(`GPB_ADDR_DIR_A, 8'h00);
  endtask
  task automatic t_in();
    wr_reg(`GPB_ADDR_OPT_B, 8'h08);
    wr_reg(`GPB_ADDR_DATA_B, 8'h09);
    settle();
    chk("ana", ana, 8'h08);
    chk("pull_fl", pu_b, 8'hE2);
    wr_reg(`GPB_ADDR_OPT_B, 8'h00);
    settle();
    chk("ana_off", ana, 8'h00);
    chk("pull_b3", pu_b, 8'hE2);
    wr_reg(`GPB_ADDR_DATA_B, 8'h00);
  endtask
  task automatic t_irq();
    wr_reg(`GPB_ADDR_OPT_A, 8'h02);
    trig_a = `GPB_TRIG_LOW;
    ea_en = 8'h02;
    settle();
    repeat (10)
    begin
      @(negedge clk);
      chk("irq_gated", {7'h00, irq_a}, 8'h00);
    end
    gen = 1'b1;
    wait_bit(irq_a, 1'b1, "irq_a");
    chk("irq_b", {7'h00, irq_b}, 8'h00);
    pwr = GPB_WAIT;
    wait_bit(wake, 1'b1, "wake_wait");
    pwr = GPB_STOP;
    settle();
    chk("wake_stop", {7'h00, wake}, 8'h01);
    chk("oe_n_stop", pa_oe_n, 8'hFF);
    pwr = GPB_RUN;
    ea_en = 8'h00;
    gen = 1'b0;
    wait_bit(irq_a, 1'b0, "irq_clr");
  endtask
  task automatic t_edge();
    wr_reg(`GPB_ADDR_OPT_B, 8'h02);
    eb = 8'h02;
    eb_en = 8'h02;
    trig_b = `GPB_TRIG_FALL;
    gen = 1'b1;
    settle();
    chk("irq_b_idle", {7'h00, irq_b}, 8'h00);
    eb = 8'h00;
    wait_bit(irq_b, 1'b1, "irq_fall");
    @(negedge clk);
    chk("fall_pulse", {7'h00, irq_b}, 8'h00);
    chk("irq_a_quiet", {7'h00, irq_a}, 8'h00);
    trig_b = `GPB_TRIG_RISE;
    settle();
    eb = 8'h02;
    wait_bit(irq_b, 1'b1, "irq_rise");
    @(negedge clk);
    chk("rise_pulse", {7'h00, irq_b}, 8'h00);
    gen = 1'b0;
    eb_en = 8'h00;
    trig_b = 2'h3;
    wr_reg(`GPB_ADDR_OPT_B, 8'h00);
  endtask
  initial
  begin
    #1ms;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    settle();
    t_regs();
    t_out();
    t_in();
    t_irq();
    t_edge();
    test_done();
  end
endmodule
